// File: sao_pkg.sv
`default_nettype none
// shared constants, field positions and types for the second output logic
package sao_pkg;

  // configuration word width and value after reset
  localparam int unsigned SAO_CFG_W          = 16;
  localparam logic [15:0] SAO_CFG_RST        = 16'h8000;

  // field positions inside the configuration word
  localparam int unsigned SAO_B_IN_UV_FLT_EN = 12;
  localparam int unsigned SAO_B_IN_UV_EN     = 7;
  localparam int unsigned SAO_B_OUT_OV_EN    = 6;
  localparam int unsigned SAO_B_OUT_UV_EN    = 5;
  localparam int unsigned SAO_B_CURR_LIM_EN  = 4;
  localparam int unsigned SAO_B_IN_OP_EN     = 3;
  localparam int unsigned SAO_B_MODE_HI      = 2;
  localparam int unsigned SAO_B_MODE_LO      = 1;
  localparam int unsigned SAO_B_POL          = 0;

  // output mode field codes
  localparam logic [1:0]  SAO_MODE_ALERT     = 2'h0;
  localparam logic [1:0]  SAO_MODE_GPIO      = 2'h1;
  localparam logic [1:0]  SAO_MODE_RSVD      = 2'h2;
  localparam logic [1:0]  SAO_MODE_CMP       = 2'h3;

  // pin level after reset (deasserted at active-low polarity)
  localparam logic        SAO_PIN_RST        = 1'b1;

  // pin behaviour states, one-hot
  typedef enum logic [3:0] {
    SAO_ST_ALERT = 4'h1,
    SAO_ST_GPIO  = 4'h2,
    SAO_ST_RSVD  = 4'h4,
    SAO_ST_CMP   = 4'h8
  } sao_state_t;

  // mode field to pin behaviour state
  function automatic sao_state_t sao_mode_state(input logic [1:0] mode);
    case (mode)
      SAO_MODE_ALERT: sao_mode_state = SAO_ST_ALERT;
      SAO_MODE_GPIO:  sao_mode_state = SAO_ST_GPIO;
      SAO_MODE_CMP:   sao_mode_state = SAO_ST_CMP;
      default:        sao_mode_state = SAO_ST_RSVD;
    endcase
  endfunction : sao_mode_state

  // electrical level for an asserted/deasserted pin under a polarity
  function automatic logic sao_pin_level(input logic asserted, input logic pol);
    sao_pin_level = pol ? asserted : ~asserted;
  endfunction : sao_pin_level

endpackage : sao_pkg
`default_nettype wire

// File: sao_cfg_if.sv
`timescale 1ns/1ns
`default_nettype none
// carries the configuration word and the combined source results
interface sao_cfg_if;
  logic [15:0] cfg_word;   // stored configuration word
  logic        alert_any;  // some enabled status or fault flag is set
  logic        cmp_any;    // some selected warning comparison is exceeded

  modport cfg_mp  (output cfg_word);
  modport comb_mp (input cfg_word, output alert_any, output cmp_any);
  modport top_mp  (input cfg_word, input alert_any, input cmp_any);
endinterface : sao_cfg_if
`default_nettype wire

// File: sao_cfg_reg.sv
`timescale 1ns/1ns
`default_nettype none
// holds the configuration word written over the management bus path
module sao_cfg_reg
  import sao_pkg::*;
(
  input  wire logic        sys_clk_i,  // device clock
  input  wire logic        rstn_i,     // async reset, active low
  input  wire logic        cfg_wr_i,   // write strobe, one cycle
  input  wire logic [15:0] cfg_wdata_i, // write data
  sao_cfg_if.cfg_mp        cfg_if      // configuration out
);

  logic [15:0] cfg_r;    // stored word
  logic [15:0] cfg_nxt;  // next word

  // a write replaces the whole word
  assign cfg_nxt = cfg_wr_i ? cfg_wdata_i : cfg_r;

  // configuration storage
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      cfg_r <= SAO_CFG_RST;
    else
      cfg_r <= cfg_nxt;
  end

  assign cfg_if.cfg_word = cfg_r;

endmodule : sao_cfg_reg
`default_nettype wire

// File: sao_src_comb.sv
`timescale 1ns/1ns
`default_nettype none
// gates status flags and warning comparisons with their enables
module sao_src_comb
  import sao_pkg::*;
(
  input  wire logic       flag_in_uv_i,   // input undervolt warning flag
  input  wire logic       flag_out_ov_i,  // output overvolt warning flag
  input  wire logic       flag_out_uv_i,  // output undervolt warning flag
  input  wire logic       flag_curr_i,    // current limit active flag
  input  wire logic       flag_in_op_i,   // input overpower warning flag
  input  wire logic       flag_uv_flt_i,  // input undervolt fault flag
  input  wire logic [3:0] cmp_warn_i,     // live warning compares {iuv,oov,ouv,iop}
  sao_cfg_if.comb_mp      cfg_if          // configuration in, results out
);

  logic [4:0] flag_vec;  // latched status flags
  logic [4:0] flag_en;   // their enables
  logic [3:0] cmp_en;    // warning enables only
  logic       flt_hit;   // enabled fault source

  assign flag_vec = {flag_in_uv_i, flag_out_ov_i, flag_out_uv_i, flag_curr_i, flag_in_op_i};
  assign flag_en  = cfg_if.cfg_word[SAO_B_IN_UV_EN:SAO_B_IN_OP_EN];
  assign flt_hit  = flag_uv_flt_i & cfg_if.cfg_word[SAO_B_IN_UV_FLT_EN];
  // any enabled flag raises the alert (R1) (R2) (R3) (R4) (R5)
  assign cfg_if.alert_any = (|(flag_vec & flag_en)) | flt_hit;

  // comparator mode sees warning compares only, faults ignored (R10)
  assign cmp_en = {cfg_if.cfg_word[SAO_B_IN_UV_EN], cfg_if.cfg_word[SAO_B_OUT_OV_EN],
                   cfg_if.cfg_word[SAO_B_OUT_UV_EN], cfg_if.cfg_word[SAO_B_IN_OP_EN]};
  // selected compares are OR'ed together (R9)
  assign cfg_if.cmp_any = |(cmp_warn_i & cmp_en);

endmodule : sao_src_comb
`default_nettype wire

// File: sao_top.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// (R1) input undervolt warning enable raises alert
// (R2) bit 6 gates output overvolt warning alert
// (R3) bit 5 gates output undervolt warning alert
// (R4) bit 4 gates current limit flag alert
// (R5) bit 3 gates input overpower warning alert
// (R6) mode defaults to alert, code 10 reserved
// (R7) mode 01: pin follows polarity bit
// (R8) mode 11: pin shows live warning compares
// (R9) comparator mode ORs all selected warnings
// (R10) comparator mode ignores fault and status flags
// (R11) bit 0: low active at 0, high at 1
// (R12) alert holds until host clears enabled flags
module sao_top
  import sao_pkg::*;
(
  input  wire logic        sys_clk_i,      // device clock, 100 MHz
  input  wire logic        rstn_i,         // async reset, active low
  input  wire logic        cfg_wr_i,       // config write strobe
  input  wire logic [15:0] cfg_wdata_i,    // config write data
  input  wire logic        flag_in_uv_i,   // input undervolt warning flag
  input  wire logic        flag_out_ov_i,  // output overvolt warning flag
  input  wire logic        flag_out_uv_i,  // output undervolt warning flag
  input  wire logic        flag_curr_i,    // current limit active flag
  input  wire logic        flag_in_op_i,   // input overpower warning flag
  input  wire logic        flag_uv_flt_i,  // input undervolt fault flag
  input  wire logic [3:0]  cmp_warn_i,     // live warning compares
  output var  logic [15:0] cfg_rdata_o,    // config read back
  output var  logic        second_output_pin_o, // pin level
  output var  logic        pin_asserted_o  // pin logically asserted
);

  // shared configuration carrier
  sao_cfg_if cfg_if ();

  // pin behaviour state and its next value
  sao_state_t state_r;
  sao_state_t state_nxt;

  // registered pin level and logical assertion
  logic       pin_r;
  logic       pin_nxt;
  logic       asrt_r;
  logic       asrt_nxt;

  // decoded configuration fields
  logic [1:0] mode_fld;   // output mode field
  logic       pol_bit;    // polarity bit

  // configuration storage
  sao_cfg_reg u_cfg
  (
    .sys_clk_i   (sys_clk_i),
    .rstn_i      (rstn_i),
    .cfg_wr_i    (cfg_wr_i),
    .cfg_wdata_i (cfg_wdata_i),
    .cfg_if      (cfg_if)
  );

  // enable gating of the sources
  sao_src_comb u_comb
  (
    .flag_in_uv_i  (flag_in_uv_i),
    .flag_out_ov_i (flag_out_ov_i),
    .flag_out_uv_i (flag_out_uv_i),
    .flag_curr_i   (flag_curr_i),
    .flag_in_op_i  (flag_in_op_i),
    .flag_uv_flt_i (flag_uv_flt_i),
    .cmp_warn_i    (cmp_warn_i),
    .cfg_if        (cfg_if)
  );

  // field decode
  assign mode_fld = cfg_if.cfg_word[SAO_B_MODE_HI:SAO_B_MODE_LO];
  assign pol_bit  = cfg_if.cfg_word[SAO_B_POL];

  // state follows the mode field; 10 maps to an idle reserved state (R6)
  assign state_nxt = sao_mode_state(mode_fld);

  // logical assertion per state
  always_comb
  begin
    case (state_r)
      // latched-flag alert: holds while any enabled flag is set (R12)
      SAO_ST_ALERT: asrt_nxt = cfg_if.alert_any;
      // software output: the polarity bit alone sets the level (R7)
      SAO_ST_GPIO:  asrt_nxt = pol_bit;
      // live unlatched compare result (R8)
      SAO_ST_CMP:   asrt_nxt = cfg_if.cmp_any;
      // reserved code: pin stays deasserted
      SAO_ST_RSVD:  asrt_nxt = 1'b0;
      default:      asrt_nxt = 1'b0;
    endcase
  end

  // pin level: gpio drives the bit itself, others apply polarity (R11)
  assign pin_nxt = (state_r == SAO_ST_GPIO) ? pol_bit
                                            : sao_pin_level(asrt_nxt, pol_bit);

  // state register
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      state_r <= SAO_ST_ALERT;
    else
      state_r <= state_nxt;
  end

  // pin and assertion registers
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pin_r  <= SAO_PIN_RST;
      asrt_r <= 1'b0;
    end
    else
    begin
      pin_r  <= pin_nxt;
      asrt_r <= asrt_nxt;
    end
  end

  // outputs straight from flops
  assign second_output_pin_o = pin_r;
  assign pin_asserted_o      = asrt_r;
  assign cfg_rdata_o         = cfg_if.cfg_word;

  // checks on the pin behaviour
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  // helper: the five latched status flags, before enable gating
  logic [4:0] flags_w;
  assign flags_w = {flag_in_uv_i, flag_out_ov_i, flag_out_uv_i, flag_curr_i, flag_in_op_i};

  // alert state with a source pending
  sequence s_alert_pending;
    (state_r == SAO_ST_ALERT) && cfg_if.alert_any;
  endsequence

  // source still pending next cycle
  sequence s_alert_held;
    s_alert_pending ##1 s_alert_pending;
  endsequence

  // input undervolt flag with its enable asserts the pin
  AST_IN_UV_ALERT: assert property ( // R1
    ((state_r == SAO_ST_ALERT) && cfg_if.cfg_word[SAO_B_IN_UV_EN] && flag_in_uv_i)
    |=> (second_output_pin_o == sao_pin_level(1'b1, $past(pol_bit))))
    else $error("input undervolt alert not raised");

  // output overvolt flag with its enable asserts the pin
  AST_OUT_OV_ALERT: assert property ( // R2
    ((state_r == SAO_ST_ALERT) && cfg_if.cfg_word[SAO_B_OUT_OV_EN] && flag_out_ov_i)
    |=> pin_asserted_o)
    else $error("output overvolt alert not raised");

  // output undervolt flag with its enable asserts the pin
  AST_OUT_UV_ALERT: assert property ( // R3
    ((state_r == SAO_ST_ALERT) && cfg_if.cfg_word[SAO_B_OUT_UV_EN] && flag_out_uv_i)
    |=> pin_asserted_o)
    else $error("output undervolt alert not raised");

  // current limit flag with its enable asserts the pin
  AST_CURR_ALERT: assert property ( // R4
    ((state_r == SAO_ST_ALERT) && cfg_if.cfg_word[SAO_B_CURR_LIM_EN] && flag_curr_i)
    |=> pin_asserted_o)
    else $error("current limit alert not raised");

  // overpower flag with its enable asserts the pin
  AST_IN_OP_ALERT: assert property ( // R5
    ((state_r == SAO_ST_ALERT) && cfg_if.cfg_word[SAO_B_IN_OP_EN] && flag_in_op_i)
    |=> pin_asserted_o)
    else $error("input overpower alert not raised");

  // masked flags never assert the pin
  AST_MASKED_QUIET: assert property ( // R2
    ((state_r == SAO_ST_ALERT) && !flag_uv_flt_i
      && ((flags_w & cfg_if.cfg_word[SAO_B_IN_UV_EN:SAO_B_IN_OP_EN]) == 5'h00))
    |=> !pin_asserted_o)
    else $error("masked flag raised alert");

  // reserved code keeps the pin deasserted
  AST_RSVD_IDLE: assert property ( // R6
    (state_r == SAO_ST_RSVD)
    |=> (second_output_pin_o == sao_pin_level(1'b0, $past(pol_bit))))
    else $error("reserved mode drove pin");

  // reserved code reaches the reserved state one cycle later
  AST_MODE_TRACK: assert property ( // R6
    (mode_fld == SAO_MODE_RSVD) |=> (state_r == SAO_ST_RSVD))
    else $error("state missed reserved mode");

  // gpio mode pin equals the polarity bit
  AST_GPIO_LEVEL: assert property ( // R7
    (state_r == SAO_ST_GPIO) |=> (second_output_pin_o == $past(pol_bit)))
    else $error("gpio level wrong");

  // comparator mode pin is the OR of selected compares
  AST_CMP_OR: assert property ( // R9
    (state_r == SAO_ST_CMP) |=> (pin_asserted_o == $past(cfg_if.cmp_any)))
    else $error("comparator OR wrong");

  // comparator mode drops as soon as the compares clear
  AST_CMP_UNLATCHED: assert property ( // R8
    ((state_r == SAO_ST_CMP) && pin_asserted_o && !cfg_if.cmp_any)
    |=> !pin_asserted_o)
    else $error("comparator output latched");

  // comparator mode ignores status and fault flags
  AST_CMP_NO_FAULT: assert property ( // R10
    ((state_r == SAO_ST_CMP) && (cmp_warn_i == 4'h0))
    |=> !pin_asserted_o)
    else $error("fault drove comparator pin");

  // level equals assertion under the polarity
  AST_POLARITY: assert property ( // R11
    (state_r != SAO_ST_GPIO)
    |=> (second_output_pin_o == sao_pin_level(pin_asserted_o, $past(pol_bit))))
    else $error("polarity wrong");

  // held source keeps the alert asserted across cycles
  AST_ALERT_HOLD: assert property ( // R12
    s_alert_held |=> pin_asserted_o && $past(pin_asserted_o))
    else $error("alert released while flag held");

  // alert releases once all enabled sources clear
  AST_ALERT_RELEASE: assert property ( // R12
    ((state_r == SAO_ST_ALERT) && !cfg_if.alert_any) |=> !pin_asserted_o)
    else $error("alert not released");

  // comparator state with a selected compare exceeded
  sequence s_cmp_hit;
    (state_r == SAO_ST_CMP) && cfg_if.cmp_any;
  endsequence

  // comparator state with every selected compare clear
  sequence s_cmp_clear;
    (state_r == SAO_ST_CMP) && !cfg_if.cmp_any;
  endsequence

  // pin behaviour state stays one-hot
  AST_STATE_ONEHOT: assert property ( // R6
    $onehot(state_r))
    else $error("pin state not one-hot");

  // alert code selects the alert state
  AST_MODE_ALERT: assert property ( // R6
    (mode_fld == SAO_MODE_ALERT) |=> (state_r == SAO_ST_ALERT))
    else $error("state missed alert mode");

  // software output code selects the gpio state
  AST_MODE_GPIO: assert property ( // R7
    (mode_fld == SAO_MODE_GPIO) |=> (state_r == SAO_ST_GPIO))
    else $error("state missed gpio mode");

  // comparator code selects the comparator state
  AST_MODE_CMP: assert property ( // R8
    (mode_fld == SAO_MODE_CMP) |=> (state_r == SAO_ST_CMP))
    else $error("state missed comparator mode");

  // reserved code keeps the logical assertion low
  AST_RSVD_NO_ASRT: assert property ( // R6
    (state_r == SAO_ST_RSVD) |=> !pin_asserted_o)
    else $error("reserved mode asserted pin");

  // gpio mode assertion follows the polarity bit
  AST_GPIO_ASRT: assert property ( // R7
    (state_r == SAO_ST_GPIO) |=> (pin_asserted_o == $past(pol_bit)))
    else $error("gpio assertion wrong");

  // an exceeded selected compare asserts the pin next cycle
  AST_CMP_HIT: assert property ( // R8
    s_cmp_hit |=> pin_asserted_o)
    else $error("comparator hit not shown");

  // cleared compares release the pin next cycle
  AST_CMP_CLEAR: assert property ( // R8
    s_cmp_clear |=> !pin_asserted_o)
    else $error("comparator clear not shown");

  // a hit followed by a clear drops the pin, no latching
  AST_CMP_HIT_CLEAR: assert property ( // R8
    s_cmp_hit ##1 s_cmp_clear |=> !pin_asserted_o)
    else $error("comparator result latched");

  // status and fault flags cannot hold up the comparator pin
  AST_CMP_IGNORES_FLAGS: assert property ( // R10
    ((state_r == SAO_ST_CMP) && !cfg_if.cmp_any && (flag_uv_flt_i || (flags_w != 5'h00)))
    |=> !pin_asserted_o)
    else $error("flag drove comparator pin");

  // enabled input undervolt fault also raises the alert
  AST_FLT_ALERT: assert property ( // R12
    ((state_r == SAO_ST_ALERT) && cfg_if.cfg_word[SAO_B_IN_UV_FLT_EN] && flag_uv_flt_i)
    |=> pin_asserted_o)
    else $error("fault alert not raised");

endmodule : sao_top
`default_nettype wire

// File: sao_top_end_marker.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// File: sao_host_mdl.sv
`timescale 1ns/1ns
`default_nettype none
// host side: watches the alert line and decodes it under the chosen polarity
module sao_host_mdl
(
  input  wire logic pin_i,   // second output pin level
  input  wire logic pol_i,   // polarity the host configured
  output wire logic alert_o  // host sees the line active
);
  // active level is high at polarity 1, low at polarity 0
  assign alert_o = (pin_i == pol_i);
endmodule : sao_host_mdl
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// bench for the second output configuration logic
module tb_top
  import sao_pkg::*;
;
  // one table row: config, flags {flt,iop,cur,ouv,oov,iuv}, compares, expected
  typedef struct {
    logic [15:0] cfg;
    logic [5:0]  flg;
    logic [3:0]  cmp;
    logic        asrt;
    logic        pin;
  } sao_row_t;

  logic        sys_clk_i   = 1'b0;   // device clock
  logic        rstn_i      = 1'b0;   // reset, active low
  logic        cfg_wr_i    = 1'b0;   // write strobe
  logic [15:0] cfg_wdata_i = 16'h0;  // write data
  logic [5:0]  flg         = 6'h0;   // status flags
  logic [3:0]  cmp         = 4'h0;   // live compares
  wire  [15:0] rdata;                // read back
  wire         pin;                  // pin level
  wire         asrt;                 // pin asserted
  wire         host_alert;           // host decode
  int          bad_count   = 0;      // mismatches
  int          checks      = 0;      // comparisons

  // ordinary cases
  sao_row_t rows [18] = '{
    '{16'h0080, 6'h01, 4'h0, 1'b1, 1'b0}, '{16'h0000, 6'h02, 4'h0, 1'b0, 1'b1},
    '{16'h0040, 6'h02, 4'h0, 1'b1, 1'b0}, '{16'h0000, 6'h04, 4'h0, 1'b0, 1'b1},
    '{16'h0020, 6'h04, 4'h0, 1'b1, 1'b0}, '{16'h0000, 6'h08, 4'h0, 1'b0, 1'b1},
    '{16'h0010, 6'h08, 4'h0, 1'b1, 1'b0}, '{16'h0000, 6'h10, 4'h0, 1'b0, 1'b1},
    '{16'h0009, 6'h10, 4'h0, 1'b1, 1'b1}, '{16'h0002, 6'h3f, 4'hf, 1'b0, 1'b0},
    '{16'h0003, 6'h00, 4'h0, 1'b1, 1'b1}, '{16'h0004, 6'h3f, 4'hf, 1'b0, 1'b1},
    '{16'h10fe, 6'h3f, 4'h0, 1'b0, 1'b1}, '{16'h0016, 6'h3f, 4'hf, 1'b0, 1'b1},
    '{16'h00c6, 6'h00, 4'h2, 1'b0, 1'b1}, '{16'h00e6, 6'h00, 4'h2, 1'b1, 1'b0},
    '{16'h1000, 6'h20, 4'h0, 1'b1, 1'b0}, '{16'h0087, 6'h00, 4'h8, 1'b1, 1'b1}
  };

  sao_top dut_u (
    .sys_clk_i           (sys_clk_i),
    .rstn_i              (rstn_i),
    .cfg_wr_i            (cfg_wr_i),
    .cfg_wdata_i         (cfg_wdata_i),
    .flag_in_uv_i        (flg[0]),
    .flag_out_ov_i       (flg[1]),
    .flag_out_uv_i       (flg[2]),
    .flag_curr_i         (flg[3]),
    .flag_in_op_i        (flg[4]),
    .flag_uv_flt_i       (flg[5]),
    .cmp_warn_i          (cmp),
    .cfg_rdata_o         (rdata),
    .second_output_pin_o (pin),
    .pin_asserted_o      (asrt)
  );

  sao_host_mdl host_u (
    .pin_i   (pin),
    .pol_i   (rdata[0]),
    .alert_o (host_alert)
  );

  // 100 MHz clock
  always #5 sys_clk_i = ~sys_clk_i;

  // compare one bit
  task automatic chk1(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e)
    begin
      $display("BAD %s expected %b seen %b", nm, e, g);
      bad_count++;
    end
  endtask : chk1

  // compare one word
  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask : chk16

  // compare the pin pair
  task automatic chk_pin(input logic a, input logic p);
    chk1("pin_asserted", a, asrt);
    chk1("pin_level", p, pin);
  endtask : chk_pin

  // one-cycle write strobe
  task automatic wr(input logic [15:0] d);
    @(negedge sys_clk_i);
    cfg_wr_i    = 1'b1;
    cfg_wdata_i = d;
    @(negedge sys_clk_i);
    cfg_wr_i    = 1'b0;
  endtask : wr

  // verdict and end of run
  task automatic results();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  // main sequence
  initial
  begin
    repeat (6) @(negedge sys_clk_i);
    rstn_i = 1'b1;
    chk16("reset_word", SAO_CFG_RST, rdata);
    chk_pin(1'b0, 1'b1);
    flg = 6'h01;
    repeat (3) @(negedge sys_clk_i);
    chk_pin(1'b0, 1'b1);
    // table of ordinary cases
    foreach (rows[i])
    begin
      wr(rows[i].cfg);
      flg = rows[i].flg;
      cmp = rows[i].cmp;
      repeat (3) @(negedge sys_clk_i);
      chk16("cfg_rdata", rows[i].cfg, rdata);
      chk_pin(rows[i].asrt, rows[i].pin);
    end
    // back-to-back writes, last one wins
    @(negedge sys_clk_i);
    cfg_wr_i    = 1'b1;
    cfg_wdata_i = 16'h0040;
    @(negedge sys_clk_i);
    cfg_wdata_i = 16'h00a0;
    @(negedge sys_clk_i);
    cfg_wr_i    = 1'b0;
    chk16("cfg_rdata_b2b", 16'h00a0, rdata);
    // alert held until every enabled flag is cleared
    flg = 6'h05;
    repeat (3) @(negedge sys_clk_i);
    chk_pin(1'b1, 1'b0);
    flg = 6'h04;
    @(negedge sys_clk_i);
    chk_pin(1'b1, 1'b0);
    chk1("host_alert", 1'b1, host_alert);
    flg = 6'h00;
    @(negedge sys_clk_i);
    chk_pin(1'b0, 1'b1);
    // comparator output follows the live compare without latching
    wr(16'h0026);
    repeat (2) @(negedge sys_clk_i);
    cmp = 4'h2;
    @(negedge sys_clk_i);
    chk_pin(1'b1, 1'b0);
    cmp = 4'h0;
    @(negedge sys_clk_i);
    chk_pin(1'b0, 1'b1);
    // reset again in mid-run
    wr(16'h0089);
    rstn_i = 1'b0;
    @(negedge sys_clk_i);
    chk16("reset_word", SAO_CFG_RST, rdata);
    chk_pin(1'b0, 1'b1);
    rstn_i = 1'b1;
    flg    = 6'h10;
    repeat (3) @(negedge sys_clk_i);
    chk_pin(1'b0, 1'b1);
    results();
  end

  // cut a hang short
  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    bad_count++;
    $display("BAD run_limit expected end seen hang");
    results();
  end
endmodule : tb_top
`default_nettype wire
